/* verilog/tw8_pkg.sv */
// Purpose: shared constants and types for the 8-bit waveform timer
// Assumes: APB slave, 32-bit data, one aligned word per register
// Notes: offsets are byte addresses
package tw8_pkg;
    localparam logic [7:0] TW8_OFS_CTRL = 8'h00;
    localparam logic [7:0] TW8_OFS_CNT = 8'h04;
    localparam logic [7:0] TW8_OFS_CMP = 8'h08;
    localparam logic [7:0] TW8_OFS_MASK = 8'h0C;
    localparam logic [7:0] TW8_OFS_FLAG = 8'h10;
    localparam logic [7:0] TW8_OFS_GIE = 8'h14;

    localparam int TW8_BIT_FOC = 7;
    localparam int TW8_BIT_WGM_LO = 6;
    localparam int TW8_BIT_COM_HI = 5;
    localparam int TW8_BIT_COM_LO = 4;
    localparam int TW8_BIT_WGM_HI = 3;
    localparam int TW8_BIT_OCIE = 1;
    localparam int TW8_BIT_TOIE = 0;
    localparam int TW8_BIT_OCF = 1;
    localparam int TW8_BIT_TOV = 0;

    localparam logic [7:0] TW8_CTRL_RST = 8'h00;
    localparam logic [7:0] TW8_MASK_RST = 8'h00;
    localparam logic [7:0] TW8_CNT_RST = 8'h00;
    localparam logic [7:0] TW8_CMP_RST = 8'h00;
    localparam logic [7:0] TW8_MAX = 8'hFF;
    localparam logic [7:0] TW8_BOTTOM = 8'h00;

    localparam logic [1:0] TW8_WGM_NORMAL = 2'h0;
    localparam logic [1:0] TW8_WGM_PCPWM = 2'h1;
    localparam logic [1:0] TW8_WGM_CLEAR_MATCH = 2'h2;
    localparam logic [1:0] TW8_WGM_FAST = 2'h3;

    localparam logic [1:0] TW8_COM_OFF = 2'h0;
    localparam logic [1:0] TW8_COM_TOGGLE = 2'h1;
    localparam logic [1:0] TW8_COM_CLEAR = 2'h2;
    localparam logic [1:0] TW8_COM_SET = 2'h3;

    localparam logic [2:0] TW8_CS_STOP = 3'h0;
    localparam logic [2:0] TW8_CS_DIV1 = 3'h1;
    localparam logic [2:0] TW8_CS_DIV8 = 3'h2;
    localparam logic [2:0] TW8_CS_DIV64 = 3'h3;
    localparam logic [2:0] TW8_CS_DIV256 = 3'h4;
    localparam logic [2:0] TW8_CS_DIV1024 = 3'h5;
    localparam logic [2:0] TW8_CS_EXT_FALL = 3'h6;
    localparam logic [2:0] TW8_CS_EXT_RISE = 3'h7;

    localparam logic [9:0] TW8_TAP8 = 10'h007;
    localparam logic [9:0] TW8_TAP64 = 10'h03F;
    localparam logic [9:0] TW8_TAP256 = 10'h0FF;
    localparam logic [9:0] TW8_TAP1024 = 10'h3FF;

    typedef struct packed {
        logic foc;
        logic [1:0] wgm;
        logic [1:0] com;
        logic [2:0] cs;
    } tw8_ctrl_s;

    typedef struct packed {
        logic wave;
        logic pin_oe;
        logic pin_override;
    } tw8_pin_s;
endpackage

/* verilog/tw8_timer.sv */
// Purpose: 8-bit timer/counter with one compare channel and four waveform modes
// Assumes: pclk 200 MHz, presetn async active low, ext pin already synchronous
// Notes: tick is a clock enable; flags clear by w1c or by vector acknowledge
`timescale 1ns/1ps
// What this block does
// - timer tick is only a clock enable
// - force strobe works in non-PWM modes only
// - force applies compare action from current bits
// - force sets no flag, never clears counter
// - force strobe always reads zero
// - mode decode; TOP is compare in clear-on-match
// - compare buffering and overflow point per mode
// - output overrides pin; driver needs direction bit
// - non-PWM: off, toggle, clear, set
// - fast PWM: match and BOTTOM actions
// - fast PWM compare equals TOP special case
// - phase PWM: up/down match actions
// - phase PWM compare equals TOP special case
// - clock select stop, 1, 8, 64, 256, 1024
// - select 6 falling, 7 rising pin edge
// - pin edges count even as output
// - counter readable and writable anytime
// - counter write blocks next tick match
// - continuous compare sets flag, drives output
// - compare irq needs enable, global, flag
// - overflow irq needs enable, global, flag
// - flags clear by vector or write one
module tw8_timer
    import tw8_pkg::*;
(
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // pins and system
    input wire logic external_count_pin,
    input wire logic pin_dir_out,
    input wire logic prescaler_clear,
    input wire logic compare_vector_ack,
    input wire logic overflow_vector_ack,
    // outputs
    output tw8_pin_s pin_out,
    output logic compare_irq,
    output logic overflow_irq
);
    tw8_ctrl_s ctrl_ff;
    logic [7:0] cnt_ff;
    logic [7:0] cmp_ff;
    logic [7:0] cmp_buf_ff;
    logic [1:0] mask_ff;
    logic gie_ff;
    logic ocf_ff;
    logic tov_ff;
    logic down_ff;
    logic wave_ff;
    logic blk_ff;
    logic [9:0] pre_ff;
    logic ext_ff;
    logic [31:0] prdata_ff;

    logic acc;
    logic wr;
    logic rd;
    logic wr_ctrl;
    logic wr_cnt;
    logic tick;
    logic is_pwm;
    logic [7:0] top;
    logic match;
    logic ovf;
    logic at_bottom;
    logic force_hit;
    logic [7:0] nxt_cnt;
    logic nxt_down;
    logic nxt_wave;
    logic wr_cmp;
    logic wr_mask;
    logic wr_flag;
    logic wr_gie;
    logic clr_ocf;
    logic clr_tov;
    logic pc_falling;
    tw8_ctrl_s ctrl_wr;

    assign acc = psel && penable;
    assign wr = acc && pwrite;
    assign rd = acc && !pwrite;
    assign pready = 1'b1;
    assign pslverr = 1'b0;
    assign prdata = prdata_ff;
    assign wr_ctrl = wr && (paddr == TW8_OFS_CTRL);
    assign wr_cnt = wr && (paddr == TW8_OFS_CNT);
    assign wr_cmp = wr && (paddr == TW8_OFS_CMP);
    assign wr_mask = wr && (paddr == TW8_OFS_MASK);
    assign wr_flag = wr && (paddr == TW8_OFS_FLAG);
    assign wr_gie = wr && (paddr == TW8_OFS_GIE);

    assign is_pwm = ctrl_ff.wgm[0];
    assign top = (ctrl_ff.wgm == TW8_WGM_CLEAR_MATCH) ? cmp_buf_ff : TW8_MAX;

    // free running prescaler, shared-style clearable
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pre_ff <= '0;
        end else if (prescaler_clear) begin
            pre_ff <= '0;
        end else begin
            pre_ff <= pre_ff + 10'h001;
        end
    end

    // pin taken as synchronous; edge detect only
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ext_ff <= 1'b0;
        end else begin
            ext_ff <= external_count_pin;
        end
    end

    always_comb begin
        case (ctrl_ff.cs)
            TW8_CS_STOP: tick = 1'b0;
            TW8_CS_DIV1: tick = 1'b1;
            TW8_CS_DIV8: tick = (pre_ff[2:0] == TW8_TAP8[2:0]);
            TW8_CS_DIV64: tick = (pre_ff[5:0] == TW8_TAP64[5:0]);
            TW8_CS_DIV256: tick = (pre_ff[7:0] == TW8_TAP256[7:0]);
            TW8_CS_DIV1024: tick = (pre_ff == TW8_TAP1024);
            TW8_CS_EXT_FALL: tick = ext_ff && !external_count_pin;
            TW8_CS_EXT_RISE: tick = !ext_ff && external_count_pin;
            default: tick = 1'b0;
        endcase
    end

    assign match = tick && !blk_ff && (cnt_ff == cmp_buf_ff);
    assign at_bottom = (cnt_ff == TW8_BOTTOM);
    // bottom turns the slope, so a match there counts as rising
    assign pc_falling = down_ff && !at_bottom;

    // counter sequence per mode, ticks act as enable only
    always_comb begin
        nxt_cnt = cnt_ff;
        nxt_down = down_ff;
        ovf = 1'b0;
        if (tick) begin
            case (ctrl_ff.wgm)
                TW8_WGM_PCPWM: begin
                    if (down_ff) begin
                        if (at_bottom) begin
                            nxt_down = 1'b0;
                            nxt_cnt = cnt_ff + 8'h01;
                            ovf = 1'b1;
                        end else begin
                            nxt_cnt = cnt_ff - 8'h01;
                        end
                    end else if (cnt_ff == top) begin
                        nxt_down = 1'b1;
                        nxt_cnt = cnt_ff - 8'h01;
                    end else begin
                        nxt_cnt = cnt_ff + 8'h01;
                    end
                end
                TW8_WGM_CLEAR_MATCH: begin
                    ovf = (cnt_ff == TW8_MAX);
                    nxt_cnt = match ? TW8_BOTTOM : cnt_ff + 8'h01;
                end
                default: begin
                    ovf = (cnt_ff == TW8_MAX);
                    nxt_cnt = cnt_ff + 8'h01;
                end
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_ff <= TW8_CNT_RST;
            down_ff <= 1'b0;
        end else if (wr_cnt) begin
            cnt_ff <= pwdata[7:0];
            down_ff <= down_ff;
        end else begin
            cnt_ff <= nxt_cnt;
            down_ff <= nxt_down;
        end
    end

    // match suppression after a counter write, until next tick
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            blk_ff <= 1'b0;
        end else if (wr_cnt) begin
            blk_ff <= 1'b1;
        end else if (tick) begin
            blk_ff <= 1'b0;
        end
    end

    // compare value with mode dependent update point
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cmp_ff <= TW8_CMP_RST;
            cmp_buf_ff <= TW8_CMP_RST;
        end else begin
            if (wr_cmp) begin
                cmp_ff <= pwdata[7:0];
            end
            if (!is_pwm) begin
                cmp_buf_ff <= wr_cmp ? pwdata[7:0] : cmp_ff;
            end else if (tick && ctrl_ff.wgm == TW8_WGM_PCPWM && cnt_ff == TW8_MAX) begin
                cmp_buf_ff <= cmp_ff;
            end else if (tick && ctrl_ff.wgm == TW8_WGM_FAST && cnt_ff == TW8_MAX) begin
                cmp_buf_ff <= cmp_ff;
            end
        end
    end

    // forced action uses the compare bits already stored
    assign force_hit = wr_ctrl && pwdata[TW8_BIT_FOC] && !is_pwm;

    // waveform generator
    always_comb begin
        nxt_wave = wave_ff;
        if (force_hit || (match && !is_pwm)) begin
            case (ctrl_ff.com)
                TW8_COM_TOGGLE: nxt_wave = !wave_ff;
                TW8_COM_CLEAR: nxt_wave = 1'b0;
                TW8_COM_SET: nxt_wave = 1'b1;
                default: nxt_wave = wave_ff;
            endcase
        end else if (ctrl_ff.wgm == TW8_WGM_FAST && ctrl_ff.com[1]) begin
            if (tick && cnt_ff == TW8_MAX) begin
                nxt_wave = !ctrl_ff.com[0];
            end else if (match && cmp_buf_ff != TW8_MAX) begin
                nxt_wave = ctrl_ff.com[0];
            end
        end else if (ctrl_ff.wgm == TW8_WGM_PCPWM && ctrl_ff.com[1]) begin
            if (cmp_buf_ff == TW8_MAX) begin
                if (tick && cnt_ff == TW8_MAX) begin
                    nxt_wave = !ctrl_ff.com[0];
                end
            end else if (match) begin
                nxt_wave = pc_falling ? !ctrl_ff.com[0] : ctrl_ff.com[0];
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wave_ff <= 1'b0;
        end else begin
            wave_ff <= nxt_wave;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pin_out <= '0;
        end else begin
            pin_out.wave <= nxt_wave;
            pin_out.pin_override <= (ctrl_ff.com != TW8_COM_OFF);
            pin_out.pin_oe <= (ctrl_ff.com != TW8_COM_OFF) && pin_dir_out;
        end
    end

    // control write data with mode bits split over 6 and 3; force never stored
    always_comb begin
        ctrl_wr = TW8_CTRL_RST;
        ctrl_wr.wgm = {pwdata[TW8_BIT_WGM_HI], pwdata[TW8_BIT_WGM_LO]};
        ctrl_wr.com = {pwdata[TW8_BIT_COM_HI], pwdata[TW8_BIT_COM_LO]};
        ctrl_wr.cs = pwdata[2:0];
    end

    // control, mask, global enable
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_ff <= TW8_CTRL_RST;
            mask_ff <= TW8_MASK_RST[1:0];
            gie_ff <= 1'b0;
        end else begin
            if (wr_ctrl) begin
                ctrl_ff <= ctrl_wr;
            end
            if (wr_mask) begin
                mask_ff <= pwdata[1:0];
            end
            if (wr_gie) begin
                gie_ff <= pwdata[0];
            end
        end
    end

    // flags: set wins over any clear; forced compare never sets
    assign clr_ocf = compare_vector_ack || (wr_flag && pwdata[TW8_BIT_OCF]);
    assign clr_tov = overflow_vector_ack || (wr_flag && pwdata[TW8_BIT_TOV]);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ocf_ff <= 1'b0;
            tov_ff <= 1'b0;
        end else begin
            if (match) begin
                ocf_ff <= 1'b1;
            end else if (clr_ocf) begin
                ocf_ff <= 1'b0;
            end
            if (ovf) begin
                tov_ff <= 1'b1;
            end else if (clr_tov) begin
                tov_ff <= 1'b0;
            end
        end
    end

    assign compare_irq = gie_ff && mask_ff[TW8_BIT_OCIE] && ocf_ff;
    assign overflow_irq = gie_ff && mask_ff[TW8_BIT_TOIE] && tov_ff;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_ff <= '0;
        end else if (psel && !penable && !pwrite) begin
            case (paddr)
                TW8_OFS_CTRL: prdata_ff <= {24'h000000, 1'b0, ctrl_ff.wgm[0], ctrl_ff.com,
                                            ctrl_ff.wgm[1], ctrl_ff.cs};
                TW8_OFS_CNT: prdata_ff <= {24'h000000, cnt_ff};
                TW8_OFS_CMP: prdata_ff <= {24'h000000, cmp_ff};
                TW8_OFS_MASK: prdata_ff <= {30'h00000000, mask_ff};
                TW8_OFS_FLAG: prdata_ff <= {30'h00000000, ocf_ff, tov_ff};
                TW8_OFS_GIE: prdata_ff <= {31'h00000000, gie_ff};
                default: prdata_ff <= '0;
            endcase
        end else if (rd) begin
            prdata_ff <= prdata_ff;
        end
    end
endmodule

/* test/tw8_timer_props.sv */
// Purpose: port-level checks for tw8_timer
// Assumes: zero-wait apb, registered pin outputs
// Notes: bound into every tw8_timer
`timescale 1ns/1ps
module tw8_timer_props
    import tw8_pkg::*;
(
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    // pins and irqs
    input wire logic pin_dir_out,
    input wire tw8_pin_s pin_out,
    input wire logic compare_irq,
    input wire logic overflow_irq
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    wire logic wr = psel && penable && pwrite;
    wire logic rd = psel && penable && !pwrite;

    a_foc_reads_zero: assert property (rd && paddr == TW8_OFS_CTRL |-> !prdata[7])
        else $error("force strobe read back as one");
    a_oe_needs_ovr: assert property (pin_out.pin_oe |-> pin_out.pin_override)
        else $error("pin driver on without override");
    a_oe_dir_cause: assert property ($rose(pin_out.pin_oe) |-> $past(pin_dir_out))
        else $error("pin driver on while direction is input");
    a_com_sets_ovr: assert property (wr && paddr == TW8_OFS_CTRL && pwdata[5:4] != 2'h0
        |-> ##[1:2] pin_out.pin_override) else $error("override missing");
    a_com_drops_ovr: assert property (wr && paddr == TW8_OFS_CTRL && pwdata[5:4] == 2'h0
        |-> ##[1:2] !pin_out.pin_override) else $error("override stuck");
    a_mask_cmp_off: assert property (wr && paddr == TW8_OFS_MASK && !pwdata[1]
        |=> !compare_irq) else $error("compare irq while disabled");
    a_mask_ovf_off: assert property (wr && paddr == TW8_OFS_MASK && !pwdata[0]
        |=> !overflow_irq) else $error("overflow irq while disabled");
    a_gie_all_off: assert property (wr && paddr == TW8_OFS_GIE && !pwdata[0]
        |=> !compare_irq && !overflow_irq) else $error("irq while global off");
    a_apb_ready: assert property (psel |-> pready && !pslverr)
        else $error("apb wait or error seen");
    a_unmapped_zero: assert property (rd && paddr > TW8_OFS_GIE |-> prdata == 32'h0)
        else $error("unmapped read not zero");
    a_reset_quiet: assert property ($rose(presetn) |-> !compare_irq && !overflow_irq)
        else $error("irq active out of reset");
endmodule
bind tw8_timer tw8_timer_props u_props (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .pin_dir_out, .pin_out, .compare_irq, .overflow_irq);

/* test/test_tw8_timer.sv */
// Purpose: directed register-level test of tw8_timer
// Assumes: zero-wait apb, timer stopped between most checks
// Notes: rate and duty checks allow small latency slack
`timescale 1ns/1ps
module test_tw8_timer import tw8_pkg::*;;
    logic pclk = 1'h0, presetn = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
    logic ecp = 1'h0, dir = 1'h1, pclr = 1'h0, cack = 1'h0, oack = 1'h0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, q, t;
    logic pready, pslverr, cirq, oirq;
    tw8_pin_s pin;
    int err_total = 0, n_compared = 0, cyc = 0, h;
    int dv[6] = '{0, 1, 8, 64, 256, 1024};
    logic [7:0] pc[5] = '{8'h69, 8'h79, 8'h61, 8'h69, 8'h61};
    logic [7:0] pv[5] = '{8'h80, 8'h80, 8'h40, 8'hFF, 8'hFF};
    int pn[5] = '{512, 512, 1020, 512, 1020};
    int pe[5] = '{258, 254, 255, 512, 1020};
    int pt[5] = '{8, 8, 8, 2, 2};

    tw8_timer i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .external_count_pin(ecp), .pin_dir_out(dir),
        .prescaler_clear(pclr), .compare_vector_ack(cack), .overflow_vector_ack(oack),
        .pin_out(pin), .compare_irq(cirq), .overflow_irq(oirq));

    initial begin
        forever #2.5 pclk = ~pclk;
    end

    task automatic end_sim();
        $display("compared %0d mismatches %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    always @(posedge pclk) begin
        cyc <= cyc + 1;
        if (cyc == 40000) begin
            err_total++;
            end_sim();
        end
    end

    task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
        n_compared++;
        if (s !== e) begin
            err_total++;
            $display("BAD %s exp %h got %h", n, e, s);
        end
    endtask

    task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d);
        @(posedge pclk);
        psel <= 1'h1;
        pwrite <= w;
        paddr <= a;
        pwdata <= {24'h0, d};
        @(posedge pclk);
        penable <= 1'h1;
        @(posedge pclk);
        while (pready !== 1'h1) @(posedge pclk);
        q = prdata;
        psel <= 1'h0;
        penable <= 1'h0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        xfer(1'h1, a, d);
    endtask

    task automatic rc(input string n, input logic [7:0] a, input logic [31:0] e);
        xfer(1'h0, a, 8'h00);
        chk(n, q, e);
    endtask

    // write mode bits, then the same with the force strobe
    task automatic fc(input logic [7:0] c, input logic e);
        wr(TW8_OFS_CTRL, c);
        wr(TW8_OFS_CTRL, c | 8'h80);
        @(negedge pclk);
        chk("wave", pin.wave, e);
    endtask

    task automatic run(input logic [7:0] c, input int w);
        wr(TW8_OFS_CTRL, c);
        repeat (w) @(posedge pclk);
        wr(TW8_OFS_CTRL, 8'h00);
    endtask

    task automatic ack_cmp();
        cack <= 1'h1;
        @(posedge pclk);
        cack <= 1'h0;
    endtask

    initial begin
        repeat (5) @(posedge pclk);
        presetn <= 1'h1;
        for (int a = 0; a < 28; a += 4) rc("reset", 8'(a), 32'h0);
        wr(TW8_OFS_CNT, 8'h05);
        rc("cnt", TW8_OFS_CNT, 32'h05);
        fc(8'h30, 1'h1);
        chk("oe", {pin.pin_oe, pin.pin_override}, 2'h3);
        rc("ctrl", TW8_OFS_CTRL, 32'h30);
        fc(8'h10, 1'h0);
        fc(8'h10, 1'h1);
        fc(8'h20, 1'h0);
        fc(8'h38, 1'h1);
        rc("cnt", TW8_OFS_CNT, 32'h05);
        rc("flag", TW8_OFS_FLAG, 32'h0);
        fc(8'h68, 1'h1);
        fc(8'h60, 1'h1);
        @(posedge pclk);
        dir <= 1'h0;
        repeat (2) @(negedge pclk);
        chk("oe", {pin.pin_oe, pin.pin_override}, 2'h1);
        @(posedge pclk);
        dir <= 1'h1;
        for (int i = 1; i < 6; i++) begin
            wr(TW8_OFS_CNT, 8'h00);
            pclr <= 1'h1;
            @(posedge pclk);
            pclr <= 1'h0;
            run(8'(i), 4 * dv[i]);
            xfer(1'h0, TW8_OFS_CNT, 8'h00);
            chk("rate", q + 1 - (4 * dv[i] + 3) / dv[i] <= 2, 1'h1);
        end
        t = q;
        repeat (20) @(posedge pclk);
        rc("stop", TW8_OFS_CNT, t);
        for (int i = 6; i < 8; i++) begin
            wr(TW8_OFS_CNT, 8'h00);
            wr(TW8_OFS_CTRL, 8'(i));
            repeat (6) begin
                ecp <= ~ecp;
                repeat (4) @(posedge pclk);
            end
            wr(TW8_OFS_CTRL, 8'h00);
            rc("ext", TW8_OFS_CNT, 32'h03);
        end
        wr(TW8_OFS_FLAG, 8'h03);
        wr(TW8_OFS_CMP, 8'h20);
        wr(TW8_OFS_CNT, 8'h20);
        run(8'h01, 10);
        rc("block", TW8_OFS_FLAG, 32'h0);
        wr(TW8_OFS_CMP, 8'hF0);
        wr(TW8_OFS_CNT, 8'hE0);
        wr(TW8_OFS_MASK, 8'h03);
        wr(TW8_OFS_GIE, 8'h01);
        run(8'h01, 60);
        rc("flag", TW8_OFS_FLAG, 32'h03);
        chk("irq", {cirq, oirq}, 2'h3);
        oack <= 1'h1;
        @(posedge pclk);
        oack <= 1'h0;
        @(negedge pclk);
        chk("oack", {cirq, oirq}, 2'h2);
        wr(TW8_OFS_MASK, 8'h00);
        @(negedge pclk);
        chk("mask", {cirq, oirq}, 2'h0);
        wr(TW8_OFS_FLAG, 8'h02);
        rc("w1c", TW8_OFS_FLAG, 32'h0);
        wr(TW8_OFS_CMP, 8'h05);
        wr(TW8_OFS_CNT, 8'h00);
        run(8'h09, 50);
        xfer(1'h0, TW8_OFS_CNT, 8'h00);
        chk("top", q <= 32'h05, 1'h1);
        rc("ctc", TW8_OFS_FLAG, 32'h02);
        ack_cmp();
        rc("cack", TW8_OFS_FLAG, 32'h0);
        for (int i = 0; i < 5; i++) begin
            wr(TW8_OFS_CMP, pv[i]);
            wr(TW8_OFS_CTRL, pc[i]);
            repeat (1100) @(posedge pclk);
            h = 0;
            repeat (pn[i]) begin
                @(negedge pclk);
                h += pin.wave;
            end
            chk("duty", (h > pe[i] ? h - pe[i] : pe[i] - h) <= pt[i], 1'h1);
        end
        wr(TW8_OFS_CTRL, 8'h00);
        wr(TW8_OFS_GIE, 8'h00);
        end_sim();
    end
endmodule
